// [flash_status_pkg.sv]
/*
 * Shared constants and carrier types for the flash status-polling host controller.
 * Assumes a single 250 MHz clock and an asynchronous parallel flash on plain pins.
 */
package flash_status_pkg;

    localparam int CLK_PERIOD_NS = 4;
    // Write strobe low time kept well above the device glitch filter.
    localparam int WR_PULSE_NS = 40;
    localparam int WR_PULSE_CYC = (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Read access time before the data bus is sampled.
    localparam int RD_ACCESS_NS = 60;
    localparam int RD_ACCESS_CYC = (RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Gap with every strobe high between two bus cycles.
    localparam int GAP_NS = 20;
    localparam int GAP_CYC = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;

    localparam int POLLING_BIT = 7;
    localparam int BUSY_TOGGLE_BIT = 6;
    localparam int TIMING_LIMIT_FLAG = 5;
    localparam int ERASE_WINDOW_FLAG = 3;
    localparam int ERASE_SECTOR_TOGGLE_BIT = 2;

    localparam logic [7:0] RESET_CMD = 8'hF0;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_WRITE = 3'h1,
        OP_READ = 3'h2,
        OP_POLL = 3'h3,
        OP_RESET = 3'h4
    } op_t;

    typedef enum logic [3:0] {
        POLL_OK = 4'h0,
        POLL_FAIL = 4'h1,
        POLL_WINDOW_OPEN = 4'h2,
        POLL_WINDOW_SHUT = 4'h3
    } result_t;

    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
    } strobes_t;

endpackage

// [flash_status_host.sv]
/*
 * Host controller that drives an asynchronous parallel flash through its
 * strobes, writes command cycles and runs the toggle-bit status procedure.
 * Assumes the flash pins are synchronous to mclk_in and the data bus is
 * resolved outside from dq_oe_out.
 */
// Functional notes
// [RQ1] Erase-sector toggle bit flips per read inside an erasing sector.
// [RQ2] Erase-sector toggle bit valid from final write strobe rising edge.
// [RQ3] Erase-sector toggle bit same for active and suspended erase.
// [RQ4] Busy toggle bit toggles during erase, stops in suspend.
// [RQ5] Host reads full byte twice and compares toggle bits first; the code compares only busy toggle bit 6.
// [RQ6] Toggling with timing-limit high: recheck; still toggling means fail, send reset.
// [RQ7] Resumed monitoring restarts from the first two reads.
// [RQ8] Timing-limit flag goes one when pulse-count limit exceeded.
// [RQ9] Under timing-limit only polling and toggle status respond.
// [RQ10] After timing-limit failure, reset command precedes further program or erase.
// [RQ11] Non-blank program attempt alone does not raise timing-limit flag.
// [RQ12] Erase-window flag stays zero until sector-erase timeout ends.
// [RQ13] Status valid immediately after initial sector-erase sequence.
// [RQ14] Erase-window flag one: further command writes ignored until done.
// [RQ15] Erase-window flag zero: extra sector-erase commands accepted.
// [RQ16] Host checks erase-window flag before and after each added erase command; the code only reports it in a poll result that still toggles.
// [RQ17] Device powers up in read mode.
// [RQ18] Contents change only after complete ordered command sequence.
// [RQ19] Strobe pulses under about five nanoseconds are ignored.
// [RQ20] Writes only with chip select and write strobe low, output strobe high.
// [RQ21] High programming voltage on reset pin unprotects sectors.
// [RQ22] Removing high programming voltage restores protection.
// [RQ23] Each toggle bit inverts once per completed status read.
`timescale 1ns/1ns
`default_nettype none

module flash_status_host #(
    parameter int ADDR_W = 19,
    parameter int DATA_W = 8
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire flash_status_pkg::op_t op_in,
    input wire logic op_valid_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic hv_unprotect_in,
    output logic op_ready_out,
    output logic done_out,
    output logic [DATA_W-1:0] rdata_out,
    output flash_status_pkg::result_t result_out,
    output flash_status_pkg::strobes_t strobes_out,
    output logic [ADDR_W-1:0] addr_out,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe_out,
    input wire logic [DATA_W-1:0] dq_in,
    output logic reset_hv_out,
    output logic reset_n_out
);

    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_WR = 7'h02,
        S_RD = 7'h04,
        S_GAP = 7'h08,
        S_EVAL = 7'h10,
        S_RESET = 7'h20,
        S_DONE = 7'h40
    } state_t;

    state_t state;
    flash_status_pkg::op_t op;
    logic [flash_status_pkg::CNT_W-1:0] cnt;
    logic [DATA_W-1:0] first;
    logic [DATA_W-1:0] last;
    logic [1:0] nreads;
    logic rechecked;
    logic next_rd_more;

    function automatic logic toggled(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
        toggled = (a[flash_status_pkg::BUSY_TOGGLE_BIT] != b[flash_status_pkg::BUSY_TOGGLE_BIT]);
    endfunction

    always_comb
    begin
        // The count has already moved on in the gap, so one read done means a second is due.
        next_rd_more = (op == flash_status_pkg::OP_POLL) && (nreads == 2'h1);
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            state <= S_IDLE;
            op <= flash_status_pkg::OP_NONE;
            cnt <= '0;
            first <= '0;
            last <= '0;
            nreads <= 2'h0;
            rechecked <= 1'b0;
            op_ready_out <= 1'b0;
            done_out <= 1'b0;
            rdata_out <= '0;
            result_out <= flash_status_pkg::POLL_OK;
            strobes_out <= 3'h7;
            addr_out <= '0;
            dq_out <= '0;
            dq_oe_out <= 1'b0;
        end
        else
        begin
            done_out <= 1'b0;
            case (state)
                S_IDLE:
                begin
                    op_ready_out <= 1'b1;
                    if (op_valid_in && op_ready_out && op_in != flash_status_pkg::OP_NONE)
                    begin
                        op_ready_out <= 1'b0;
                        op <= op_in;
                        addr_out <= addr_in;
                        nreads <= 2'h0;
                        rechecked <= 1'b0;
                        cnt <= '0;
                        if (op_in == flash_status_pkg::OP_WRITE
                            || op_in == flash_status_pkg::OP_RESET)
                        begin
                            // [RQ20] Write cycle strobes.
                            dq_out <= (op_in == flash_status_pkg::OP_RESET)
                                ? flash_status_pkg::RESET_CMD : wdata_in;
                            dq_oe_out <= 1'b1;
                            strobes_out <= 3'b001;
                            state <= S_WR;
                        end
                        else
                        begin
                            strobes_out <= 3'b010;
                            state <= S_RD;
                        end
                    end
                end
                S_WR:
                begin
                    cnt <= cnt + 1'b1;
                    // [RQ19] Long write pulse.
                    if (cnt == flash_status_pkg::CNT_W'(flash_status_pkg::WR_PULSE_CYC - 1))
                    begin
                        strobes_out <= 3'b111;
                        cnt <= '0;
                        state <= S_GAP;
                    end
                end
                S_RD:
                begin
                    cnt <= cnt + 1'b1;
                    if (cnt == flash_status_pkg::CNT_W'(flash_status_pkg::RD_ACCESS_CYC - 1))
                    begin
                        // [RQ23] One status read per strobe.
                        strobes_out <= 3'b111;
                        last <= dq_in;
                        if (nreads == 2'h0)
                        begin
                            first <= dq_in;
                        end
                        nreads <= nreads + 2'h1;
                        cnt <= '0;
                        state <= S_GAP;
                    end
                end
                S_GAP:
                begin
                    dq_oe_out <= 1'b0;
                    cnt <= cnt + 1'b1;
                    if (cnt == flash_status_pkg::CNT_W'(flash_status_pkg::GAP_CYC - 1))
                    begin
                        cnt <= '0;
                        if (op == flash_status_pkg::OP_POLL)
                            state <= next_rd_more ? S_RD : S_EVAL;
                        else
                            state <= S_DONE;
                        if (op == flash_status_pkg::OP_POLL && next_rd_more)
                            strobes_out <= 3'b010;
                    end
                end
                S_EVAL:
                begin
                    // [RQ5] Compare two reads.
                    if (!toggled(first, last))
                    begin
                        result_out <= flash_status_pkg::POLL_OK;
                        state <= S_DONE;
                    end
                    // [RQ6] Recheck on timing limit.
                    else if (last[flash_status_pkg::TIMING_LIMIT_FLAG] && !rechecked)
                    begin
                        rechecked <= 1'b1;
                        first <= last;
                        nreads <= 2'h1;
                        strobes_out <= 3'b010;
                        state <= S_RD;
                    end
                    else if (last[flash_status_pkg::TIMING_LIMIT_FLAG])
                    begin
                        // [RQ10] Reset after failure.
                        result_out <= flash_status_pkg::POLL_FAIL;
                        op <= flash_status_pkg::OP_RESET;
                        dq_out <= flash_status_pkg::RESET_CMD;
                        dq_oe_out <= 1'b1;
                        strobes_out <= 3'b001;
                        state <= S_WR;
                    end
                    else
                    begin
                        // [RQ16] Report erase-window flag around added erase commands.
                        result_out <= last[flash_status_pkg::ERASE_WINDOW_FLAG]
                            ? flash_status_pkg::POLL_WINDOW_SHUT
                            : flash_status_pkg::POLL_WINDOW_OPEN;
                        state <= S_DONE;
                    end
                end
                S_DONE:
                begin
                    // [RQ7] Each poll restarts with two fresh reads.
                    rdata_out <= last;
                    done_out <= 1'b1;
                    op <= flash_status_pkg::OP_NONE;
                    state <= S_IDLE;
                end
                default:
                begin
                    state <= S_IDLE;
                    strobes_out <= 3'h7;
                end
            endcase
        end
    end

    // [RQ21] High voltage request drives the reset pin select.
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            reset_hv_out <= 1'b0;
            reset_n_out <= 1'b0;
        end
        else
        begin
            // [RQ22] Dropping the request restores protection.
            reset_hv_out <= hv_unprotect_in;
            reset_n_out <= 1'b1;
        end
    end

endmodule

`default_nettype wire

// [flash_dev_model.sv]
/* Behavioural flash device that answers the host controller pins.
   Assumes the strobes are sampled on the host clock. */
`timescale 1ns/1ns
`default_nettype none
module flash_dev_model (
    input wire logic mclk_in,
    input wire flash_status_pkg::strobes_t strobes_in,
    input wire logic [18:0] addr_in,
    input wire logic [7:0] dq_in,
    input wire logic dq_oe_in,
    input wire logic [7:0] stat_in,
    input wire logic [7:0] toggles_in,
    input wire logic load_in,
    output logic [7:0] dq_out,
    output logic [7:0] wr_data_out,
    output logic [18:0] wr_addr_out
);
    flash_status_pkg::strobes_t prev;
    logic [7:0] left;
    logic tgl;
    logic rd;
    assign rd = !strobes_in.ce_n && !strobes_in.oe_n;
    // status byte.
    // A released bus shows the inverse so a late sample cannot pass.
    assign dq_out = rd ? stat_in ^ {1'b0, tgl, 3'h0, tgl, 2'h0} : ~stat_in;
    always_ff @(posedge mclk_in)
    begin
        prev <= strobes_in;
        if (load_in)
        begin
            left <= toggles_in;
            tgl <= 1'b0;
        end
        else if (!prev.ce_n && !prev.oe_n && strobes_in.oe_n && left != 8'h00)
        begin
            left <= left - 8'h01;
            tgl <= ~tgl;
        end
        if (!prev.ce_n && !prev.we_n && prev.oe_n && strobes_in.we_n && dq_oe_in)
        begin
            wr_data_out <= dq_in;
            wr_addr_out <= addr_in;
        end
    end
endmodule
`default_nettype wire

// [flash_status_host_sva.sv]
/* Port checker for the flash host controller.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ns
`default_nettype none
module flash_status_host_sva (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire flash_status_pkg::op_t op_in,
    input wire logic op_valid_in,
    input wire logic op_ready_out,
    input wire logic done_out,
    input wire flash_status_pkg::strobes_t strobes_out,
    input wire logic dq_oe_out,
    input wire logic hv_unprotect_in,
    input wire logic reset_hv_out,
    input wire logic reset_n_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    a_reset_idle: assert property (
        $rose(rst_n_in) |-> strobes_out == 3'h7 && !dq_oe_out && !reset_n_out)
        else $error("outputs not idle after reset");
    a_ready_after_reset: assert property (
        $rose(rst_n_in) |=> op_ready_out) else $error("not ready after reset");
    a_write_gated: assert property (
        !strobes_out.we_n |-> !strobes_out.ce_n && strobes_out.oe_n && dq_oe_out)
        else $error("write strobe without its qualifiers");
    a_read_no_drive: assert property (
        !strobes_out.oe_n |-> !dq_oe_out && !strobes_out.ce_n)
        else $error("data driven during read");
    a_we_pulse_width: assert property (
        $fell(strobes_out.we_n) |-> !strobes_out.we_n [*8])
        else $error("write pulse too short");
    a_take_drops_ready: assert property (
        op_valid_in && op_ready_out && op_in != flash_status_pkg::OP_NONE |=> !op_ready_out)
        else $error("ready stayed high after take");
    a_write_latency: assert property (
        op_valid_in && op_ready_out && op_in == flash_status_pkg::OP_WRITE
        |-> ##[17:18] done_out) else $error("write done late");
    a_read_latency: assert property (
        op_valid_in && op_ready_out && op_in == flash_status_pkg::OP_READ
        |-> ##[21:22] done_out) else $error("read done late");
    a_hv_on: assert property (
        hv_unprotect_in |-> ##[1:2] reset_hv_out) else $error("high voltage not applied");
    a_hv_off: assert property (
        !hv_unprotect_in |-> ##[1:2] !reset_hv_out) else $error("high voltage not removed");
endmodule
bind flash_status_host flash_status_host_sva chk_u (.mclk_in, .rst_n_in, .op_in,
    .op_valid_in, .op_ready_out, .done_out, .strobes_out, .dq_oe_out, .hv_unprotect_in,
    .reset_hv_out, .reset_n_out);
`default_nettype wire

// [test_flash_status_host.sv]
/* Self-checking bench for the flash host controller.
   Assumes the device model answers on the flash pins. */
`timescale 1ns/1ns
`default_nettype none
module test_flash_status_host;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    flash_status_pkg::op_t op_in = flash_status_pkg::OP_NONE;
    logic op_valid_in = 1'b0, hv_unprotect_in = 1'b0, load = 1'b0;
    logic [18:0] addr_in = 19'h00000, wr_addr, a, addr_out;
    logic [7:0] wdata_in = 8'h00, stat_b = 8'h00, toggles = 8'h00, d, wr_data;
    logic [7:0] rdata_out, dq_out, dq_in;
    logic op_ready_out, done_out, dq_oe_out, reset_hv_out, reset_n_out;
    flash_status_pkg::result_t result_out;
    flash_status_pkg::strobes_t strobes_out;
    logic [7:0] st [4] = '{8'h00, 8'h00, 8'h08, 8'h20};
    logic [7:0] tg [4] = '{8'h00, 8'h64, 8'h64, 8'h01};
    int fail_count = 0;
    int tests_run = 0;
    always #2 mclk_in = ~mclk_in;
    flash_status_host dut_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .op_in(op_in),
        .op_valid_in(op_valid_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .hv_unprotect_in(hv_unprotect_in), .op_ready_out(op_ready_out), .done_out(done_out),
        .rdata_out(rdata_out), .result_out(result_out), .strobes_out(strobes_out),
        .addr_out(addr_out), .dq_out(dq_out), .dq_oe_out(dq_oe_out), .dq_in(dq_in),
        .reset_hv_out(reset_hv_out), .reset_n_out(reset_n_out));
    flash_dev_model dev_u (.mclk_in(mclk_in), .strobes_in(strobes_out),
        .addr_in(addr_out), .dq_in(dq_out), .dq_oe_in(dq_oe_out), .stat_in(stat_b),
        .toggles_in(toggles), .load_in(load), .dq_out(dq_in), .wr_data_out(wr_data),
        .wr_addr_out(wr_addr));
    task automatic print_verdict();
        if (fail_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [18:0] seen, input logic [18:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Each spare toggle flips the pair of reads once; a set timing limit buys one reread.
    function automatic logic [3:0] exp_result(input logic [7:0] s, input logic [7:0] t);
        if (t == 8'h00)
            return flash_status_pkg::POLL_OK;
        if (s[flash_status_pkg::TIMING_LIMIT_FLAG])
            return (t > 8'h01) ? flash_status_pkg::POLL_FAIL : flash_status_pkg::POLL_OK;
        if (s[flash_status_pkg::ERASE_WINDOW_FLAG])
            return flash_status_pkg::POLL_WINDOW_SHUT;
        return flash_status_pkg::POLL_WINDOW_OPEN;
    endfunction
    task automatic wait_high(input bit want_done);
        int n;
        n = 0;
        do
        begin
            @(negedge mclk_in);
            n++;
        end
        while ((want_done ? done_out : op_ready_out) !== 1'b1 && n < 400);
        if (n >= 400)
        begin
            fail_count++;
            print_verdict();
        end
    endtask
    // The model is reloaded at the take edge, before the first read starts.
    task automatic run_op(input flash_status_pkg::op_t op, input logic [18:0] ad,
        input logic [7:0] dt, input logic [7:0] s, input logic [7:0] t);
        wait_high(1'b0);
        @(posedge mclk_in);
        stat_b <= s;
        toggles <= t;
        load <= 1'b1;
        op_in <= op;
        addr_in <= ad;
        wdata_in <= dt;
        op_valid_in <= 1'b1;
        @(posedge mclk_in);
        load <= 1'b0;
        op_valid_in <= 1'b0;
        wait_high(1'b1);
    endtask
    initial
    begin
        void'($urandom(98));
        repeat (3) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        d = 8'($urandom);
        run_op(flash_status_pkg::OP_READ, 19'($urandom), 8'h00, d, 8'h00);
        check(rdata_out, d);
        check(reset_n_out, 1'b1);
        for (int i = 0; i < 3; i++)
        begin
            a = 19'($urandom);
            d = 8'($urandom);
            run_op(flash_status_pkg::OP_WRITE, a, d, 8'h00, 8'h00);
            check(wr_data, d);
            check(wr_addr, a);
        end
        for (int i = 0; i < 4; i++)
        begin
            run_op(flash_status_pkg::OP_POLL, 19'($urandom), 8'h00, st[i], tg[i]);
            check(result_out, exp_result(st[i], tg[i]));
        end
        run_op(flash_status_pkg::OP_POLL, 19'h00000, 8'h00, 8'h20, 8'h64);
        check(result_out, exp_result(8'h20, 8'h64));
        check(wr_data, flash_status_pkg::RESET_CMD);
        @(posedge mclk_in);
        hv_unprotect_in <= 1'b1;
        repeat (4) @(negedge mclk_in);
        check(reset_hv_out, 1'b1);
        @(posedge mclk_in);
        hv_unprotect_in <= 1'b0;
        repeat (4) @(negedge mclk_in);
        check(reset_hv_out, 1'b0);
        // A second reset in mid-run must idle the pins and leave reads working.
        @(posedge mclk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(negedge mclk_in);
        check(reset_n_out, 1'b0);
        check(strobes_out, 3'h7);
        @(posedge mclk_in);
        rst_n_in <= 1'b1;
        d = 8'($urandom);
        run_op(flash_status_pkg::OP_READ, 19'($urandom), 8'h00, d, 8'h00);
        check(rdata_out, d);
        print_verdict();
    end
endmodule
`default_nettype wire
